// [logic/sclkp_pkg.sv]
/*
  Package for the system clock select and prescaler block: fuse codes,
  register layout, reset values and start-up timing.
  Assumes a 40 MHz sys_clk; all users refer to names as sclkp_pkg::name.
*/
package sclkp_pkg;

  // Clock source select fuse codes
  localparam logic [3:0] SRC_EXTERNAL = 4'h0;
  localparam logic [3:0] SRC_LOWPOWER_128K = 4'h3;

  // Start-up time fuse codes
  localparam logic [1:0] START_SHORT = 2'h0;
  localparam logic [1:0] START_FAST = 2'h1;
  localparam logic [1:0] START_SLOW = 2'h2;

  // Prescale control register layout
  localparam int CHANGE_ENABLE_BIT = 7;
  localparam logic [7:0] PRESCALE_ARM_VALUE = 8'h80;
  localparam logic [3:0] PRESCALE_MAX_CODE = 4'h8;
  localparam logic [3:0] PRESCALE_RESET_DIV1 = 4'h0;
  localparam logic [3:0] PRESCALE_RESET_DIV8 = 4'h3;
  localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

  // Register offsets
  localparam logic [1:0] ADDR_PRESCALE = 2'h0;
  localparam logic [1:0] ADDR_ASYNC_STATUS = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int TIMER_EXT_CLOCK_BIT = 6;

  // Start-up delays, in source clock cycles and in milliseconds
  localparam logic [3:0] WAKE_CYCLES = 4'h6;
  localparam logic [3:0] RESET_CYCLES = 4'hE;
  localparam real CLK_MHZ = 40.0;
  localparam real LP_FAST_MS = 4.0;
  localparam real LP_SLOW_MS = 64.0;
  localparam real EXT_FAST_MS = 4.1;
  localparam real EXT_SLOW_MS = 65.0;
  localparam int LP_FAST_CYC = int'($ceil(LP_FAST_MS * CLK_MHZ * 1000.0));
  localparam int LP_SLOW_CYC = int'($ceil(LP_SLOW_MS * CLK_MHZ * 1000.0));
  localparam int EXT_FAST_CYC = int'($ceil(EXT_FAST_MS * CLK_MHZ * 1000.0));
  localparam int EXT_SLOW_CYC = int'($ceil(EXT_SLOW_MS * CLK_MHZ * 1000.0));
  localparam int DELAY_W = 22;

  typedef enum logic [1:0] {SCLKP_ST_DELAY, SCLKP_ST_RUN, SCLKP_ST_HALT} sclkp_state_t;

endpackage

// [logic/sclkp_sync.sv]
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module sclkp_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sclkp_sync_t;

  sclkp_sync_t s_reg;
  sclkp_sync_t s_next;

  always_comb begin
    s_next.meta = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule

// [logic/sclkp_divider.sv]
/*
  Glitch-free divider: a counter on the undivided clock, cleared at each boundary, and a clock
  enable pulse whose divisor only changes at a divided-period boundary.
  Assumes select codes are already limited to the legal range.
*/
`timescale 1ns/10ps
module sclkp_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic src_tick,
  input wire logic [3:0] select,
  // Divided clock
  output logic div_tick,
  output logic div_level,
  output logic [3:0] active_select
);

  typedef struct packed {
    logic [7:0] count;
    logic [3:0] active;
    logic tick;
    logic level;
  } sclkp_div_t;

  sclkp_div_t d_reg;
  sclkp_div_t d_next;
  logic [7:0] mask;

  always_comb begin
    mask = 8'(({8'h0, 1'b1} << d_reg.active) - 9'h001);
    d_next = d_reg;
    d_next.tick = 1'b0;
    if (src_tick) begin
      // Count state is internal only
      if ((d_reg.count & mask) == mask) begin
        d_next.count = 8'h00;
        d_next.tick = 1'b1;
        // Switch only at the boundary: no short period appears
        d_next.active = select;
      end else begin
        d_next.count = 8'(d_reg.count + 8'h01);
      end
      d_next.level = ((d_next.count & mask) <= (mask >> 1)) && (d_next.active != 4'h0)
                     ? 1'b1 : (d_next.active == 4'h0 ? ~d_reg.level : 1'b0);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign div_tick = d_reg.tick;
  assign div_level = d_reg.level;
  assign active_select = d_reg.active;

endmodule

// [logic/sclkp_top.sv]
/*
  System clock source select, start-up delay, clock output and
  programmable prescaler with a timed two-step unlock.
  Assumes fuses are static straps, and that pins are asynchronous.
*/
`timescale 1ns/10ps
module sclkp_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Fuses
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic clock_output_fuse,
  input wire logic divide_by_eight_fuse,
  // Clock sources
  input wire logic external_clock_input_pin,
  input wire logic lowpower_osc_tick,
  input wire logic timer_osc_input_pin,
  input wire logic timer_crystal_tick,
  input wire logic wake_request,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Clock outputs
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  output logic system_clock_tick,
  output logic system_clock_ready,
  output logic timer_clock_tick
);

  typedef struct packed {
    sclkp_pkg::sclkp_state_t state;
    logic [3:0] select;
    logic armed;
    logic [2:0] arm_count;
    logic timer_ext;
    logic [21:0] delay;
    logic strap_done;
    logic ext_prev;
    logic tosc_prev;
    logic timer_tick;
    logic [7:0] rdata;
  } sclkp_top_t;

  sclkp_top_t r_reg;
  sclkp_top_t r_next;
  logic ext_sync;
  logic tosc_sync;
  logic src_tick;
  logic div_tick;
  logic div_level;
  logic [3:0] active_select;
  logic source_ok;
  logic [21:0] reset_delay;

  sclkp_sync u_ext_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(external_clock_input_pin),
    .sync_out(ext_sync)
  );

  sclkp_sync u_tosc_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(timer_osc_input_pin),
    .sync_out(tosc_sync)
  );

  always_comb begin
    source_ok = 1'b1;
    src_tick = 1'b0;
    case (clock_source_select_fuses)
      sclkp_pkg::SRC_LOWPOWER_128K: src_tick = lowpower_osc_tick;
      sclkp_pkg::SRC_EXTERNAL: src_tick = ext_sync & ~r_reg.ext_prev;
      default: source_ok = 1'b0;
    endcase
  end

  // Reset delay: 14 source cycles for the short code, else a fixed time in sys_clk cycles
  always_comb begin
    reset_delay = 22'(sclkp_pkg::RESET_CYCLES);
    case (startup_time_fuses)
      sclkp_pkg::START_FAST: begin
        if (clock_source_select_fuses == sclkp_pkg::SRC_EXTERNAL) begin
          reset_delay = 22'(sclkp_pkg::EXT_FAST_CYC);
        end else begin
          reset_delay = 22'(sclkp_pkg::LP_FAST_CYC);
        end
      end
      sclkp_pkg::START_SLOW: begin
        if (clock_source_select_fuses == sclkp_pkg::SRC_EXTERNAL) begin
          reset_delay = 22'(sclkp_pkg::EXT_SLOW_CYC);
        end else begin
          reset_delay = 22'(sclkp_pkg::LP_SLOW_CYC);
        end
      end
      default: reset_delay = 22'(sclkp_pkg::RESET_CYCLES);
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.ext_prev = ext_sync;
    r_next.tosc_prev = tosc_sync;
    r_next.rdata = 8'h00;
    // Timer source: crystal, or the external pin only when selected
    r_next.timer_tick = r_reg.timer_ext ? (tosc_sync & ~r_reg.tosc_prev)
                                        : timer_crystal_tick;
    // Strap caught once after reset release
    if (!r_reg.strap_done) begin
      r_next.strap_done = 1'b1;
      r_next.select = divide_by_eight_fuse ? sclkp_pkg::PRESCALE_RESET_DIV8
                                           : sclkp_pkg::PRESCALE_RESET_DIV1;
      // Short code counts 14 source cycles, fast and slow codes count sys_clk cycles
      r_next.delay = reset_delay;
    end
    case (r_reg.state)
      sclkp_pkg::SCLKP_ST_DELAY: begin
        // Reserved start-up code 11 or unknown source never starts
        if (r_reg.strap_done && source_ok && startup_time_fuses != 2'h3) begin
          if (r_reg.delay == 22'h0) begin
            r_next.state = sclkp_pkg::SCLKP_ST_RUN;
          end else if (src_tick || startup_time_fuses != sclkp_pkg::START_SHORT) begin
            r_next.delay = 22'(r_reg.delay - 22'h1);
          end
        end
      end
      sclkp_pkg::SCLKP_ST_RUN: begin
        if (wake_request) begin
          r_next.state = sclkp_pkg::SCLKP_ST_HALT;
          r_next.delay = 22'(sclkp_pkg::WAKE_CYCLES);
        end
      end
      sclkp_pkg::SCLKP_ST_HALT: begin
        if (r_reg.delay == 22'h0) begin
          r_next.state = sclkp_pkg::SCLKP_ST_RUN;
        end else if (src_tick) begin
          r_next.delay = 22'(r_reg.delay - 22'h1);
        end
      end
      default: r_next.state = sclkp_pkg::SCLKP_ST_DELAY;
    endcase
    // Arm window: fixed from the arming write, not extended
    if (r_reg.armed) begin
      if (r_reg.arm_count == sclkp_pkg::ARM_WINDOW_CYCLES - 3'h1) begin
        r_next.armed = 1'b0;
      end
      r_next.arm_count = 3'(r_reg.arm_count + 3'h1);
    end
    if (reg_write) begin
      case (reg_addr)
        sclkp_pkg::ADDR_PRESCALE: begin
          if (reg_wdata == sclkp_pkg::PRESCALE_ARM_VALUE) begin
            if (!r_reg.armed) begin
              r_next.armed = 1'b1;
              r_next.arm_count = 3'h0;
            end
          end else if (!reg_wdata[sclkp_pkg::CHANGE_ENABLE_BIT]) begin
            if (r_reg.armed) begin
              r_next.armed = 1'b0;
              // Reserved codes ignored to keep a legal divisor
              if (reg_wdata[3:0] <= sclkp_pkg::PRESCALE_MAX_CODE) begin
                r_next.select = reg_wdata[3:0];
              end
            end
            // Unarmed writes leave the select alone
          end
        end
        sclkp_pkg::ADDR_ASYNC_STATUS: begin
          r_next.timer_ext = reg_wdata[sclkp_pkg::TIMER_EXT_CLOCK_BIT];
        end
        default: r_next.timer_ext = r_reg.timer_ext;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        sclkp_pkg::ADDR_PRESCALE: r_next.rdata = {r_reg.armed, 3'h0, r_reg.select};
        sclkp_pkg::ADDR_ASYNC_STATUS: begin
          r_next.rdata = 8'(r_reg.timer_ext) << sclkp_pkg::TIMER_EXT_CLOCK_BIT;
        end
        sclkp_pkg::ADDR_STATUS: begin
          r_next.rdata = {2'h0, r_reg.state == sclkp_pkg::SCLKP_ST_RUN, source_ok,
                          active_select};
        end
        default: r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Counter on undivided ticks; divisor swaps at a boundary only
  sclkp_divider u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .src_tick(src_tick),
    .select(r_reg.select),
    .div_tick(div_tick),
    .div_level(div_level),
    .active_select(active_select)
  );

  // Divided clock on the pin while the fuse is set, held low while it is clear
  assign clock_output_pin = div_level & clock_output_fuse;
  assign clock_output_pin_oe = clock_output_fuse;
  assign system_clock_tick = div_tick & (r_reg.state == sclkp_pkg::SCLKP_ST_RUN);
  assign system_clock_ready = r_reg.state == sclkp_pkg::SCLKP_ST_RUN;
  assign timer_clock_tick = r_reg.timer_tick;
  assign reg_rdata = r_reg.rdata;

endmodule

// [test/sclkp_checker.sv]
/*
  Checker for sclkp_top: clock output gating and the prescale unlock.
  Assumes only the top module's ports are visible; bound at the foot.
*/
`timescale 1ns/10ps
module sclkp_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Clock output
  input wire logic clock_output_fuse,
  input wire logic clock_output_pin,
  input wire logic clock_output_pin_oe,
  input wire logic system_clock_tick,
  input wire logic system_clock_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_arm;
    reg_write && reg_addr == 2'h0 && reg_wdata == 8'h80;
  endsequence
  sequence s_rd0;
    reg_read && reg_addr == 2'h0;
  endsequence
  a_oe_fuse: assert property (clock_output_pin_oe == clock_output_fuse)
    else $error("pin enable differs from fuse");
  a_pin_quiet: assert property (!clock_output_fuse |-> !clock_output_pin)
    else $error("clock pin driven without fuse");
  a_tick_running: assert property (system_clock_tick |-> system_clock_ready)
    else $error("tick while not running");
  a_arm_sets: assert property (s_arm ##1 s_rd0 |=> reg_rdata[7])
    else $error("change enable not armed");
  a_arm_expires: assert property (s_arm ##1 (!reg_write)[*4] ##1 s_rd0 |=> !reg_rdata[7])
    else $error("change enable outlived its window");
  a_select_taken: assert property (s_arm ##1 (reg_write && reg_addr == 2'h0 &&
    reg_wdata <= 8'h08) ##1 s_rd0 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("armed select write not taken");
  a_code_legal: assert property (s_rd0 |=> reg_rdata[3:0] <= 4'h8)
    else $error("reserved select code held");
  a_unarmed_keep: assert property (s_rd0 ##1 (!reg_write)[*4] ##1 (reg_write &&
    reg_addr == 2'h0 && !reg_wdata[7]) ##1 s_rd0 |=>
    reg_rdata[3:0] == $past(reg_rdata[3:0], 6))
    else $error("unarmed write changed select");
endmodule

bind sclkp_top sclkp_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .clock_output_fuse(clock_output_fuse), .clock_output_pin(clock_output_pin),
  .clock_output_pin_oe(clock_output_pin_oe), .system_clock_tick(system_clock_tick),
  .system_clock_ready(system_clock_ready));

// [test/sclkp_ext_src.sv]
/*
  External clock source on the clock input pin.
  Assumes a steady period unrelated to sys_clk; low while stopped.
*/
`timescale 1ns/10ps
module sclkp_ext_src #(parameter real HALF_NS = 37.3) (
  // Control
  input wire logic run,
  // Clock pin
  output logic pin
);
  // Fixed period keeps cycle-to-cycle drift at zero
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule

// [test/sclkp_tb.sv]
/*
  Self-checking bench for sclkp_top: start-up, prescale unlock and
  division, timer clock select. Assumes the source model and checker.
*/
`timescale 1ns/10ps
module sclkp_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] src_fuse = 4'h0;
  logic div8_fuse = 1'b0;
  logic out_fuse = 1'b0;
  logic ext_run = 1'b0;
  logic lp_run = 1'b0;
  logic lp_tick = 1'b0;
  logic tosc_pin = 1'b0;
  logic xtal_tick = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic rd_pend = 1'b0;
  logic ext_pin, clk_pin, clk_oe, sys_tick, ready, tmr_tick;
  logic [7:0] reg_rdata;
  logic [15:0] e;
  logic [15:0] expq[$];
  int fail_count = 0;
  int n_tests = 0;
  int tick_cnt = 0;
  int tmr_cnt = 0;
  int gap = 0;
  int min_gap = 0;
  int seed = 32'hB553CFCB;

  initial forever #12.5 sys_clk = ~sys_clk;

  sclkp_ext_src u_src (.run(ext_run), .pin(ext_pin));
  sclkp_top DUT (.sys_clk(sys_clk), .rstn(rstn), .clock_source_select_fuses(src_fuse),
    .startup_time_fuses(2'h0), .clock_output_fuse(out_fuse), .divide_by_eight_fuse(div8_fuse),
    .external_clock_input_pin(ext_pin), .lowpower_osc_tick(lp_tick),
    .timer_osc_input_pin(tosc_pin), .timer_crystal_tick(xtal_tick), .wake_request(1'b0),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .clock_output_pin(clk_pin), .clock_output_pin_oe(clk_oe),
    .system_clock_tick(sys_tick), .system_clock_ready(ready), .timer_clock_tick(tmr_tick));

  always @(posedge sys_clk) begin
    rd_pend <= reg_read;
    lp_tick <= lp_run & ~lp_tick;
    if (tmr_tick === 1'b1) tmr_cnt++;
    if (sys_tick === 1'b1) begin
      tick_cnt++;
      if (gap < min_gap) min_gap = gap;
      gap = 1;
    end else gap++;
  end
  // Read data stands only in the cycle after the read
  always @(negedge sys_clk) begin
    if (rd_pend && expq.size() > 0) begin
      e = expq.pop_front();
      check(reg_rdata & e[15:8], e[7:0]);
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task op(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task idle(input int n);
    repeat (n) op(1'b0, 1'b0, 2'h0, 8'h00);
  endtask
  task rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] x);
    expq.push_back({m, x});
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  task do_reset(input logic [3:0] s, input logic d8, input logic of);
    @(posedge sys_clk);
    rstn <= 1'b0;
    src_fuse <= s;
    div8_fuse <= d8;
    out_fuse <= of;
    repeat (10) @(posedge sys_clk);
    check(8'(clk_oe), 8'(of));
    rstn <= 1'b1;
    idle(22);
    check(8'(ready), 8'h00);
  endtask
  task wait_rdy();
    int i;
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge sys_clk);
    if (i == 400) begin
      fail_count++;
      end_sim();
    end
  endtask
  task train(input logic [7:0] x);
    int t0;
    t0 = tmr_cnt;
    repeat (5) begin
      @(posedge sys_clk);
      tosc_pin <= 1'b1;
      repeat (2) begin
        xtal_tick <= 1'b1;
        @(posedge sys_clk);
        xtal_tick <= 1'b0;
        @(posedge sys_clk);
      end
      tosc_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
    check(8'(tmr_cnt - t0), x);
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    int i;
    int g;
    int t0;
    int pc;
    logic [3:0] code;
    do_reset(4'h5, 1'b0, 1'b0);
    idle(200);
    check(8'(ready), 8'h00);
    ext_run <= 1'b1;
    do_reset(4'h0, 1'b0, 1'b1);
    wait_rdy();
    ext_run <= 1'b0;
    lp_run <= 1'b1;
    do_reset(4'h3, 1'b1, 1'b1);
    wait_rdy();
    rd(2'h0, 8'h8F, 8'h03);
    rd(2'h2, 8'h3F, 8'h33);
    rd(2'h3, 8'hFF, 8'h00);
    do_reset(4'h3, 1'b0, 1'b1);
    wait_rdy();
    rd(2'h0, 8'hFF, 8'h00);
    pc = 0;
    for (i = 0; i < 9; i++) begin
      code = 4'((i * 5) % 9);
      g = (i == 0) ? 1 : 1 + ($unsigned($random(seed)) % 4);
      op(1'b1, 1'b0, 2'h0, 8'h80);
      // Nothing else is issued between the two steps
      idle(g - 1);
      op(1'b1, 1'b0, 2'h0, {4'h0, code});
      rd(2'h0, 8'hFF, {4'h0, code});
      min_gap = 1000;
      idle((4 << pc) + (6 << code) + 8);
      check(8'(min_gap >= (2 << ((pc < code) ? pc : code))), 8'h01);
      t0 = tick_cnt;
      idle(16 << code);
      check(8'(tick_cnt - t0), 8'h08);
      rd(2'h2, 8'h3F, 8'h30 | {4'h0, code});
      pc = code;
    end
    rd(2'h0, 8'h0F, 4'(pc));
    idle(4);
    op(1'b1, 1'b0, 2'h0, 8'h07);
    rd(2'h0, 8'h0F, 4'(pc));
    op(1'b1, 1'b0, 2'h0, 8'h80);
    idle(4);
    rd(2'h0, 8'h8F, 4'(pc));
    op(1'b1, 1'b0, 2'h0, 8'h01);
    rd(2'h0, 8'h0F, 4'(pc));
    op(1'b1, 1'b0, 2'h0, 8'h80);
    idle(1);
    op(1'b1, 1'b0, 2'h0, 8'h80);
    idle(2);
    op(1'b1, 1'b0, 2'h0, 8'h01);
    rd(2'h0, 8'h0F, 4'(pc));
    op(1'b1, 1'b0, 2'h0, 8'h81);
    op(1'b1, 1'b0, 2'h0, 8'h02);
    rd(2'h0, 8'h8F, 4'(pc));
    for (i = 9; i < 16; i++) begin
      op(1'b1, 1'b0, 2'h0, 8'h80);
      rd(2'h0, 8'h80, 8'h80);
      op(1'b1, 1'b0, 2'h0, 8'(i));
      rd(2'h0, 8'h8F, 4'(pc));
    end
    op(1'b1, 1'b0, 2'h1, 8'h40);
    rd(2'h1, 8'h40, 8'h40);
    idle(1);
    train(8'h05);
    op(1'b1, 1'b0, 2'h1, 8'h00);
    idle(1);
    train(8'h0A);
    end_sim();
  end
endmodule
